/* File: shared/lsd_pkg.sv */
/*
 * lsd_pkg: constants, register layout and types for the listen duty-cycle timer.
 * Assumes a 10 MHz core clock and 32-bit AXI4-Lite register access, one word per register.
 */
package lsd_pkg;

	// core clock period
	localparam int CLK_PERIOD_NS = 100;

	// resolution time bases, in nanoseconds as printed
	localparam int RES_64US_NS = 64000;
	localparam int RES_4MS_NS = 4100000;
	localparam int RES_262MS_NS = 262000000;

	// resolution time bases in clock cycles
	localparam int RES_64US_CYC = RES_64US_NS / CLK_PERIOD_NS;
	localparam int RES_4MS_CYC = RES_4MS_NS / CLK_PERIOD_NS;
	localparam int RES_262MS_CYC = RES_262MS_NS / CLK_PERIOD_NS;

	// width of the resolution divider
	localparam int TICK_CNT_W = 22;

	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_TIMING = 6'h0D;
	localparam logic [5:0] IDX_IDLE_COEF = 6'h0E;
	localparam logic [5:0] IDX_RX_COEF = 6'h0F;
	localparam logic [5:0] IDX_REVISION = 6'h10;
	localparam logic [5:0] IDX_CONTROL = 6'h14;
	localparam logic [5:0] IDX_STATUS = 6'h15;

	// values after reset
	localparam logic [7:0] RST_TIMING = 8'h92;
	localparam logic [7:0] RST_IDLE_COEF = 8'hF5;
	localparam logic [7:0] RST_RX_COEF = 8'h20;
	localparam logic [7:0] RST_CONTROL = 8'h00;

	// resolution codes
	localparam logic [1:0] RES_RSVD = 2'h0;
	localparam logic [1:0] RES_64US = 2'h1;
	localparam logic [1:0] RES_4MS = 2'h2;
	localparam logic [1:0] RES_262MS = 2'h3;

	// post-acceptance action codes
	localparam logic [1:0] END_STAY_RX = 2'h0;
	localparam logic [1:0] END_GO_MODE = 2'h1;
	localparam logic [1:0] END_RESUME = 2'h2;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// listen_timing_control layout
	typedef struct packed {
		logic [1:0] idle_phase_resolution;
		logic [1:0] receive_phase_resolution;
		logic acceptance_criterion;
		logic [1:0] post_acceptance_action;
		logic unused0;
	} lsd_timing_t;

	// listen_control layout
	typedef struct packed {
		logic [3:0] unused;
		logic [2:0] exit_mode;
		logic listen_on;
	} lsd_control_t;

	// sequencer states
	typedef enum logic [2:0] {
		ST_OFF,
		ST_IDLE,
		ST_RX,
		ST_HOLD,
		ST_STOP,
		ST_DONE
	} lsd_state_t;

	// listen_status layout
	typedef struct packed {
		logic [2:0] unused;
		logic rx_on;
		logic discard_pending;
		logic [2:0] state;
	} lsd_status_t;

endpackage

/* File: src/lsd_listen_timer.sv */
/*
 * lsd_listen_timer: listen-mode duty-cycle sequencer with its AXI4-Lite register file.
 * Assumes the modem flags below are synchronous to aclk and that the mode sequencer
 * outside acts on mode_req_valid.
 *
// Summary of operation
// (RL1) idle resolution codes select 64us, 4.1ms, 262ms
// (RL2) receive resolution codes select 64us, 4.1ms, 262ms
// (RL3) accept on strength, optionally plus sync match
// (RL4) action 00: stay receiving, stop listening
// (RL5) action 01: after payload/timeout, go to mode
// (RL6) action 10: after payload/timeout, resume idle
// (RL7) action 10: discard buffer at next receive
// (RL8) idle time is coefficient times resolution
// (RL9) receive time is coefficient times resolution
// (RL10) revision: full revision high, mask low
// (RL11) alternate idle and receive while listening
 */
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module lsd_listen_timer
	import lsd_pkg::*;
#(
	parameter int RES_4MS_CYCLES = RES_4MS_CYC,
	parameter int RES_262MS_CYCLES = RES_262MS_CYC,
	parameter logic [3:0] FULL_REVISION = 4'h1, // arbitrary value
	parameter logic [3:0] MASK_REVISION = 4'h1 // arbitrary value
)
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// modem and packet engine flags
	input wire logic signal_strength_limit,
	input wire logic sync_addr_match,
	input wire logic payload_complete_flag,
	input wire logic rx_timeout_flag,
	// sequencer outputs
	output logic rx_enable,
	output logic fifo_discard,
	output logic listen_active,
	output logic mode_req_valid,
	output logic [2:0] mode_request
);

	lsd_timing_t timing; // listen_timing_control
	logic [7:0] idle_coef; // listen_idle_coefficient
	logic [7:0] rx_coef; // listen_receive_coefficient
	lsd_control_t control; // listen_control
	lsd_state_t state;
	lsd_state_t next_state;
	logic [7:0] phase_cnt; // resolution ticks elapsed in this phase
	logic discard_pending; // buffer must be flushed at next receive
	logic res_tick;
	logic [1:0] res_sel;
	logic [7:0] coef;
	logic phase_end;
	logic accept;
	logic rx_done;
	logic restart;
	// bus holding registers
	logic aw_held;
	logic w_held;
	logic [5:0] aw_idx;
	logic [7:0] w_byte;
	logic w_lane0;
	logic wr_fire;
	logic [31:0] rd_data;
	logic rd_err;
	lsd_status_t status;

	// the running phase picks which resolution and coefficient apply
	assign res_sel = (state == ST_IDLE) ? timing.idle_phase_resolution : timing.receive_phase_resolution; // RL1 RL2
	assign coef = (state == ST_IDLE) ? idle_coef : rx_coef;
	// a phase ends on the tick that completes coef ticks; zero ends on the first
	assign phase_end = res_tick && (({1'b0, phase_cnt} + 9'h001) >= {1'b0, coef}); // RL8 RL9
	assign accept = signal_strength_limit && (!timing.acceptance_criterion || sync_addr_match); // RL3
	assign rx_done = payload_complete_flag || rx_timeout_flag;
	assign restart = (next_state != state);

	lsd_res_tick #(
		.P_64US(RES_64US_CYC),
		.P_4MS(RES_4MS_CYCLES),
		.P_262MS(RES_262MS_CYCLES)
	) u_tick (
		.aclk(aclk),
		.aresetn(aresetn),
		.restart(restart),
		.sel(res_sel),
		.tick(res_tick)
	);

	// sequencer next state; disabling listen mode overrides everything
	always_comb
	begin
		next_state = state;
		case (state)
			ST_OFF:
				next_state = ST_IDLE;
			ST_IDLE:
				if (phase_end)
					next_state = ST_RX; // RL11
			ST_RX:
				if (accept)
					next_state = (timing.post_acceptance_action == END_STAY_RX) ? ST_STOP : ST_HOLD; // RL3 RL4
				else if (phase_end)
					next_state = ST_IDLE; // RL11
			ST_HOLD:
				if (rx_done)
				begin
					// reserved code 11 behaves as resume
					if (timing.post_acceptance_action == END_GO_MODE || timing.post_acceptance_action == END_STAY_RX)
						next_state = ST_DONE; // RL5
					else
						next_state = ST_IDLE; // RL6
				end
			default:
				next_state = state; // stopped: wait for software to disable
		endcase
		if (!control.listen_on)
			next_state = ST_OFF; // RL4 RL5
	end

	// state register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			state <= ST_OFF;
		else
			state <= next_state;
	end

	// phase tick counter, cleared whenever a phase begins
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			phase_cnt <= 8'h00;
		else if (restart)
			phase_cnt <= 8'h00;
		else if (res_tick)
			phase_cnt <= phase_cnt + 8'h01; // RL8 RL9
	end

	// flush request survives the idle phase and fires as receive starts
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			discard_pending <= 1'b0;
			fifo_discard <= 1'b0;
		end
		else
		begin
			fifo_discard <= discard_pending && state == ST_IDLE && next_state == ST_RX; // RL7
			if (state == ST_HOLD && next_state == ST_IDLE)
				discard_pending <= 1'b1; // RL7
			else if (next_state == ST_RX || next_state == ST_OFF)
				discard_pending <= 1'b0;
		end
	end

	// registered sequencer outputs
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rx_enable <= 1'b0;
			listen_active <= 1'b0;
			mode_req_valid <= 1'b0;
			mode_request <= 3'h0;
		end
		else
		begin
			// receive phase time includes receiver startup, so enable from phase start
			rx_enable <= next_state == ST_RX || next_state == ST_HOLD || next_state == ST_STOP; // RL4 RL9
			listen_active <= next_state == ST_IDLE || next_state == ST_RX || next_state == ST_HOLD;
			mode_req_valid <= state == ST_HOLD && next_state == ST_DONE; // RL5
			if (state == ST_HOLD && next_state == ST_DONE)
				mode_request <= control.exit_mode; // RL5
		end
	end

	// write address channel: one held address until the response is taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			aw_idx <= 6'h00;
			s_axi_awready <= 1'b0;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held <= 1'b1;
			aw_idx <= s_axi_awaddr[7:2];
			s_axi_awready <= 1'b0;
		end
		else
		begin
			if (wr_fire)
				aw_held <= 1'b0;
			s_axi_awready <= !aw_held && !s_axi_bvalid;
		end
	end

	// write data channel; only byte lane 0 carries register bits
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_held <= 1'b0;
			w_byte <= 8'h00;
			w_lane0 <= 1'b0;
			s_axi_wready <= 1'b0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_held <= 1'b1;
			w_byte <= s_axi_wdata[7:0];
			w_lane0 <= s_axi_wstrb[0];
			s_axi_wready <= 1'b0;
		end
		else
		begin
			if (wr_fire)
				w_held <= 1'b0;
			s_axi_wready <= !w_held && !s_axi_bvalid;
		end
	end

	assign wr_fire = aw_held && w_held && !s_axi_bvalid;

	// write response; unmapped indices answer SLVERR, read-only ones are ignored
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end
		else if (wr_fire)
		begin
			s_axi_bvalid <= 1'b1;
			if (aw_idx == IDX_TIMING || aw_idx == IDX_IDLE_COEF || aw_idx == IDX_RX_COEF
				|| aw_idx == IDX_REVISION || aw_idx == IDX_CONTROL || aw_idx == IDX_STATUS)
				s_axi_bresp <= RESP_OKAY;
			else
				s_axi_bresp <= RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// writable registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			timing <= lsd_timing_t'(RST_TIMING);
			idle_coef <= RST_IDLE_COEF; // RL8
			rx_coef <= RST_RX_COEF; // RL9
			control <= lsd_control_t'(RST_CONTROL);
		end
		else if (wr_fire && w_lane0)
		begin
			if (aw_idx == IDX_TIMING)
			begin
				timing <= lsd_timing_t'(w_byte);
				timing.unused0 <= 1'b0; // unused bit reads zero
			end
			else if (aw_idx == IDX_IDLE_COEF)
				idle_coef <= w_byte;
			else if (aw_idx == IDX_RX_COEF)
				rx_coef <= w_byte;
			else if (aw_idx == IDX_CONTROL)
			begin
				control <= lsd_control_t'(w_byte);
				control.unused <= 4'h0;
			end
		end
	end

	assign status = '{unused: 3'h0, rx_on: rx_enable, discard_pending: discard_pending, state: state};

	// read decode
	always_comb
	begin
		rd_data = 32'h0000_0000;
		rd_err = 1'b0;
		if (s_axi_araddr[7:2] == IDX_TIMING)
			rd_data[7:0] = timing;
		else if (s_axi_araddr[7:2] == IDX_IDLE_COEF)
			rd_data[7:0] = idle_coef;
		else if (s_axi_araddr[7:2] == IDX_RX_COEF)
			rd_data[7:0] = rx_coef;
		else if (s_axi_araddr[7:2] == IDX_REVISION)
			rd_data[7:0] = {FULL_REVISION, MASK_REVISION}; // RL10
		else if (s_axi_araddr[7:2] == IDX_CONTROL)
			rd_data[7:0] = control;
		else if (s_axi_araddr[7:2] == IDX_STATUS)
			rd_data[7:0] = status;
		else
			rd_err = 1'b1;
	end

	// read channel: data captured at the address handshake
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_data;
			s_axi_rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
		end
		else
		begin
			if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
		end
	end

	// helper: cycles since the last divider wrap or phase start, for period checks
	// the tick flop shows a wrap one cycle late, so a tick reloads one rather than zero
	logic [TICK_CNT_W-1:0] gap;
	always_ff @(posedge aclk)
	begin
		if (!aresetn || restart)
			gap <= '0;
		else if (res_tick)
			gap <= TICK_CNT_W'(1);
		else
			gap <= gap + 1'b1;
	end

	sequence s_hold_done;
		state == ST_HOLD && rx_done && control.listen_on;
	endsequence

	sequence s_rx_start_flush;
		state == ST_IDLE && discard_pending && phase_end && control.listen_on;
	endsequence

	a_idle_res_base: assert property (@(posedge aclk) disable iff (!aresetn) // RL1
		(state == ST_IDLE && res_tick && !$past(restart) && timing.idle_phase_resolution == RES_64US)
		|-> $past(gap) == TICK_CNT_W'(RES_64US_CYC - 1))
		else $error("idle 64us base has wrong period");

	a_rx_res_base: assert property (@(posedge aclk) disable iff (!aresetn) // RL2
		(state == ST_RX && res_tick && !$past(restart) && timing.receive_phase_resolution == RES_64US)
		|-> $past(gap) == TICK_CNT_W'(RES_64US_CYC - 1))
		else $error("receive 64us base has wrong period");

	a_accept_leaves: assert property (@(posedge aclk) disable iff (!aresetn) // RL3
		(state == ST_RX && accept && control.listen_on) |=> (state == ST_STOP || state == ST_HOLD))
		else $error("accepted packet did not end the receive phase");

	a_sync_required: assert property (@(posedge aclk) disable iff (!aresetn) // RL3
		(state == ST_RX && timing.acceptance_criterion && !sync_addr_match && !phase_end && control.listen_on)
		|=> state == ST_RX)
		else $error("packet accepted without sync match");

	a_stay_rx_stop: assert property (@(posedge aclk) disable iff (!aresetn) // RL4
		(state == ST_STOP && control.listen_on) ##1 control.listen_on |=> rx_enable && state == ST_STOP)
		else $error("stopped listen left receive");

	a_go_mode: assert property (@(posedge aclk) disable iff (!aresetn) // RL5
		(s_hold_done and timing.post_acceptance_action == END_GO_MODE)
		|=> mode_req_valid && !rx_enable && mode_request == $past(control.exit_mode))
		else $error("mode request missing after payload");

	a_resume_idle: assert property (@(posedge aclk) disable iff (!aresetn) // RL6
		(s_hold_done and timing.post_acceptance_action == END_RESUME) |=> state == ST_IDLE && discard_pending)
		else $error("listen did not resume in idle");

	a_flush_at_rx: assert property (@(posedge aclk) disable iff (!aresetn) // RL7
		s_rx_start_flush |=> fifo_discard && rx_enable ##1 !fifo_discard)
		else $error("buffer not discarded at receive start");

	a_idle_length: assert property (@(posedge aclk) disable iff (!aresetn) // RL8
		(state == ST_IDLE && res_tick && control.listen_on && phase_cnt == idle_coef - 8'h01) |=> state == ST_RX)
		else $error("idle phase length wrong");

	a_rx_length: assert property (@(posedge aclk) disable iff (!aresetn) // RL9 RL11
		(state == ST_RX && res_tick && !accept && control.listen_on && phase_cnt == rx_coef - 8'h01)
		|=> state == ST_IDLE && !rx_enable)
		else $error("receive phase length wrong");

	a_revision_read: assert property (@(posedge aclk) disable iff (!aresetn) // RL10
		(s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == IDX_REVISION)
		|=> s_axi_rvalid && s_axi_rdata == {24'h000000, FULL_REVISION, MASK_REVISION})
		else $error("revision read wrong");

endmodule

/* File: src/lsd_res_tick.sv */
/*
 * lsd_res_tick: resolution time base; one-cycle tick every period of the selected code.
 * Assumes restart is pulsed when a phase begins so each phase starts on a full period.
 */
`timescale 1ns/1ps
module lsd_res_tick
	import lsd_pkg::*;
#(
	parameter int P_64US = RES_64US_CYC,
	parameter int P_4MS = RES_4MS_CYC,
	parameter int P_262MS = RES_262MS_CYC
)
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// control
	input wire logic restart,
	input wire logic [1:0] sel,
	// time base
	output logic tick
);

	logic [TICK_CNT_W-1:0] cnt; // cycles into the current period
	logic [TICK_CNT_W-1:0] last; // terminal count of the selected base

	// reserved code runs on the shortest base so a phase can never hang
	always_comb
	begin
		if (sel == RES_4MS)
			last = TICK_CNT_W'(P_4MS - 1);
		else if (sel == RES_262MS)
			last = TICK_CNT_W'(P_262MS - 1);
		else
			last = TICK_CNT_W'(P_64US - 1);
	end

	// divider and tick flop
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cnt <= '0;
			tick <= 1'b0;
		end
		else if (restart)
		begin
			cnt <= '0;
			tick <= 1'b0;
		end
		else if (cnt >= last)
		begin
			cnt <= '0;
			tick <= 1'b1;
		end
		else
		begin
			cnt <= cnt + 1'b1;
			tick <= 1'b0;
		end
	end

endmodule

/* File: tb/lsd_listen_timer_tb_top.sv */
/*
 * lsd_listen_timer_tb_top: self-checking bench for the listen duty-cycle timer.
 * Assumes the shortened 4.1 ms and 262 ms bases set below; the 64 us base stays 640 cycles.
 */
`timescale 1ns/1ps
module lsd_listen_timer_tb_top
	import lsd_pkg::*;
;
	localparam int P4 = 41; // shortened 4.1 ms base
	localparam int P262 = 262; // shortened 262 ms base
	localparam logic [7:0] REV = 8'h37; // arbitrary revision value
	// clock, reset and bus signals
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	// modem flags and sequencer outputs
	logic strength, sync, payload, tmo;
	logic rx_enable, fifo_discard, listen_active, mode_req_valid;
	logic [2:0] mode_request;
	int error_cnt, num_checks, cyc;

	lsd_listen_timer #(.RES_4MS_CYCLES(P4), .RES_262MS_CYCLES(P262), .FULL_REVISION(REV[7:4]),
		.MASK_REVISION(REV[3:0])) uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.signal_strength_limit(strength), .sync_addr_match(sync), .payload_complete_flag(payload),
		.rx_timeout_flag(tmo), .rx_enable(rx_enable), .fifo_discard(fifo_discard),
		.listen_active(listen_active), .mode_req_valid(mode_req_valid), .mode_request(mode_request));

	// free-running 10 MHz clock
	initial
	begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	// hang guard: the whole run needs well under this many cycles
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 90000)
		begin
			error_cnt = error_cnt + 1;
			wrap_up();
		end
	end

	// verdict and end of run
	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// one comparison, four-state exact
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks = num_checks + 1;
		if (seen !== exp)
		begin
			error_cnt = error_cnt + 1;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// expected tick period in cycles for a resolution code (reserved code runs as 64 us)
	function automatic int period(input logic [1:0] c);
		case (c)
			RES_4MS: return P4;
			RES_262MS: return P262;
			default: return 640;
		endcase
	endfunction

	// timing register image
	function automatic logic [7:0] tcfg(input logic [1:0] i, r, input logic c, input logic [1:0] a);
		return {i, r, c, a, 1'b0};
	endfunction

	// write one register; address and data offered together, each dropped once taken
	task automatic axi_write(input logic [5:0] idx, input logic [7:0] d, output logic [1:0] resp);
		bit aw_done;
		bit w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge aclk);
		awaddr <= {idx, 2'h0};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// local flags: the valid signals read back their old value in this time step
		while (!(aw_done && w_done))
		begin
			@(posedge aclk);
			if (awready === 1'b1)
				aw_done = 1'b1;
			if (wready === 1'b1)
				w_done = 1'b1;
			if (aw_done)
				awvalid <= 1'b0;
			if (w_done)
				wvalid <= 1'b0;
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask

	// read one register; rready held until the answer is sampled
	task automatic axi_read(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] resp);
		@(posedge aclk);
		araddr <= {idx, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1)
			@(posedge aclk);
		d = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask

	// read and compare data and response
	task automatic expect_rd(input logic [5:0] idx, input logic [7:0] exp, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		axi_read(idx, d, r);
		check("read data", d, {24'h0, exp});
		check("read resp", 32'(r), 32'(er));
	endtask

	// stop listening, program timing and coefficients, then start with an exit mode
	task automatic cfg(input logic [7:0] tim, ic, rc, input logic [2:0] ex);
		logic [1:0] r;
		axi_write(IDX_CONTROL, 8'h00, r);
		axi_write(IDX_TIMING, tim, r);
		axi_write(IDX_IDLE_COEF, ic, r);
		axi_write(IDX_RX_COEF, rc, r);
		axi_write(IDX_CONTROL, {4'h0, ex, 1'b1}, r);
	endtask

	// wait for the receive phase to open
	task automatic wait_rx();
		while (rx_enable !== 1'b1)
			@(posedge aclk);
	endtask

	// short signal burst at the start of a receive phase, then a wait past the phase end
	task automatic hit(input logic s);
		wait_rx();
		strength <= 1'b1;
		sync <= s;
		repeat (2) @(posedge aclk);
		strength <= 1'b0;
		sync <= 1'b0;
		repeat (200) @(posedge aclk);
	endtask

	// one-cycle pulse on a completion flag, then count output pulses
	task automatic pulse_count(input bit use_tmo, output int dis, output int mr);
		dis = 0;
		mr = 0;
		if (use_tmo)
			tmo <= 1'b1;
		else
			payload <= 1'b1;
		@(posedge aclk);
		tmo <= 1'b0;
		payload <= 1'b0;
		repeat (4)
		begin
			@(posedge aclk);
			mr = mr + int'(mode_req_valid);
			dis = dis + int'(fifo_discard);
		end
	endtask

	// main sequence
	initial
	begin
		int il, rl, dis, mr;
		logic [7:0] v;
		logic [2:0] ex;
		logic [1:0] r;
		{aresetn, awvalid, wvalid, bready, arvalid, rready, strength, sync, payload, tmo} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hF;
		error_cnt = 0;
		num_checks = 0;
		void'($urandom(53));
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		// reset values, revision, unmapped and read-only places
		expect_rd(IDX_TIMING, RST_TIMING, RESP_OKAY);
		expect_rd(IDX_IDLE_COEF, 8'hF5, RESP_OKAY);
		expect_rd(IDX_RX_COEF, 8'h20, RESP_OKAY);
		expect_rd(IDX_REVISION, REV, RESP_OKAY);
		axi_write(IDX_REVISION, 8'h00, r);
		expect_rd(IDX_REVISION, REV, RESP_OKAY);
		axi_write(6'h20, 8'h5A, r);
		check("unmapped write resp", 32'(r), 32'(RESP_SLVERR));
		expect_rd(6'h20, 8'h00, RESP_SLVERR);
		axi_write(IDX_TIMING, 8'hFF, r);
		expect_rd(IDX_TIMING, 8'hFE, RESP_OKAY);
		// random coefficient round trips
		repeat (4)
		begin
			v = 8'($urandom);
			axi_write(IDX_IDLE_COEF, v, r);
			expect_rd(IDX_IDLE_COEF, v, RESP_OKAY);
			axi_write(IDX_RX_COEF, ~v, r);
			expect_rd(IDX_RX_COEF, ~v, RESP_OKAY);
		end
		// byte lane 0 disabled: the coefficient must not change
		wstrb <= 4'h0;
		axi_write(IDX_IDLE_COEF, ~v, r);
		wstrb <= 4'hF;
		expect_rd(IDX_IDLE_COEF, v, RESP_OKAY);
		// phase lengths over every resolution code, no signal present
		for (int c = 0; c < 4; c++)
		begin
			v = 8'($urandom_range(3, 1));
			cfg(tcfg(2'(c), 2'(3 - c), 1'b0, END_RESUME), v, 8'(4 - v), 3'h0);
			wait_rx();
			rl = 0;
			il = 0;
			while (rx_enable === 1'b1)
			begin
				@(posedge aclk);
				rl++;
			end
			while (rx_enable === 1'b0)
			begin
				@(posedge aclk);
				il++;
			end
			check("rx length", 32'(rl >= (4 - v) * period(2'(3 - c)) && rl <= (4 - v) * period(2'(3 - c)) + 2), 1);
			check("idle length", 32'(il >= v * period(2'(c)) && il <= v * period(2'(c)) + 2), 1);
		end
		// go-to-mode action: strength alone refused under sync criterion, then accepted
		ex = 3'($urandom);
		cfg(tcfg(RES_4MS, RES_4MS, 1'b1, END_GO_MODE), 8'h08, 8'h04, ex);
		expect_rd(IDX_CONTROL, {4'h0, ex, 1'b1}, RESP_OKAY);
		hit(1'b0);
		check("rx without sync", 32'(rx_enable), 0);
		hit(1'b1);
		check("rx held after accept", 32'(rx_enable), 1);
		pulse_count(1'b0, dis, mr);
		check("mode request pulses", 32'(mr), 1);
		check("mode request", 32'(mode_request), 32'(ex));
		check("rx after payload", 32'(rx_enable), 0);
		check("listen stopped", 32'(listen_active), 0);
		expect_rd(IDX_STATUS, 8'h05, RESP_OKAY);
		// stay-in-receive action: strength alone accepts
		cfg(tcfg(RES_4MS, RES_4MS, 1'b0, END_STAY_RX), 8'h08, 8'h04, 3'h0);
		hit(1'b0);
		check("rx stays", 32'(rx_enable), 1);
		check("listen stopped", 32'(listen_active), 0);
		pulse_count(1'b0, dis, mr);
		check("rx ignores payload", 32'(rx_enable), 1);
		check("no mode request", 32'(mr), 0);
		expect_rd(IDX_STATUS, 8'h14, RESP_OKAY);
		axi_write(IDX_CONTROL, 8'h00, r);
		repeat (2) @(posedge aclk);
		check("rx off after disable", 32'(rx_enable), 0);
		// resume action: timeout ends receive, buffer flushed at the next receive phase only
		cfg(tcfg(RES_4MS, RES_4MS, 1'b0, END_RESUME), 8'h08, 8'h04, 3'h0);
		hit(1'b0);
		pulse_count(1'b1, dis, mr);
		check("rx after timeout", 32'(rx_enable), 0);
		check("listening again", 32'(listen_active), 1);
		dis = 0;
		while (rx_enable !== 1'b1)
		begin
			@(posedge aclk);
			dis = dis + int'(fifo_discard);
		end
		repeat (3)
		begin
			@(posedge aclk);
			dis = dis + int'(fifo_discard);
		end
		check("flush pulses", 32'(dis), 1);
		while (rx_enable === 1'b1)
			@(posedge aclk);
		wait_rx();
		check("listen keeps cycling", 32'(listen_active), 1);
		wrap_up();
	end
endmodule
